// ---- inc/pktl_pkg.sv ----
package pktl_pkg;
  // key and hash geometry
  localparam int HDR_W = 320;
  localparam int DW_W = 32;
  localparam int HDR_DW = 10;
  localparam int HASH_W = 56;
  localparam int PROF_W = 4;
  localparam int KEY_W = 60;
  localparam int C8_LO = 48;
  localparam int C16_LO = 32;
  localparam int C32_LO = 0;
  // crc polynomials, widths and seeds
  localparam logic [31:0] CRC32_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC16_POLY = 32'h0000_1021;
  localparam logic [31:0] CRC8_POLY = 32'h0000_0007;
  localparam logic [31:0] CRC_SEED = 32'hFFFF_FFFF;
  localparam int CRC32_W = 32;
  localparam int CRC16_W = 16;
  localparam int CRC8_W = 8;
  // register map
  localparam logic [11:0] REG_TREE_ROOT = 12'hF18;
  // memory layout
  localparam logic [31:0] NULL_ADDR = 32'h0000_0000;
  localparam logic [31:0] DFLT_BASE = 32'h0000_1800;
  localparam logic [31:0] DFLT_STRIDE = 32'h0000_0080;
  localparam logic [31:0] DW_BYTES = 32'h0000_0004;
  localparam int FETCH_DEPTH = 16;
  localparam logic [4:0] NODE_DW = 5'h05;
  localparam int NODE_KEY_LO = 0;
  localparam int NODE_KEY_HI = 1;
  localparam int NODE_LEFT = 2;
  localparam int NODE_RIGHT = 3;
  localparam int NODE_CONF = 4;
  localparam logic [4:0] CONF_DW = 5'h0D;
  localparam int CONF_NEXT = 10;
  localparam int CONF_ACT = 11;
  localparam int CONF_FLOW = 12;
  // action dword fields
  localparam int ACT_DEST_LO = 0;
  localparam int ACT_RELOOK = 2;
  localparam int ACT_PROF_LO = 3;
  localparam int ACT_SETFLOW = 7;
  localparam int ACT_PROTO_LO = 8;
  localparam int ACT_DROP = 12;
  localparam int PROTO_W = 4;
  localparam logic [3:0] PROTO_UNKNOWN = 4'h0;
  localparam logic [2:0] MAX_RELOOK = 3'h4;

  typedef enum logic [1:0] {
    PKTL_DEST_DISASM = 2'h0,
    PKTL_DEST_CPU = 2'h1,
    PKTL_DEST_PORT_A = 2'h2,
    PKTL_DEST_PORT_B = 2'h3
  } pktl_dest_t;

  typedef enum logic [1:0] {
    PKTL_KIND_HDR = 2'h0,
    PKTL_KIND_ELAN = 2'h1,
    PKTL_KIND_LABEL = 2'h2,
    PKTL_KIND_OVERLAY = 2'h3
  } pktl_kind_t;

  typedef struct packed {
    logic [HDR_W-1:0] hdr;
    logic [HDR_W-1:0] mask;
    logic [PROF_W-1:0] profile;
    logic [DW_W-1:0] flow_ptr;
    pktl_kind_t kind;
    logic [PROTO_W-1:0] label_stack_upper_proto_tag;
    logic [PROTO_W-1:0] multiproto_overlay_upper_proto_tag;
  } pktl_req_t;

  typedef struct packed {
    pktl_dest_t dest;
    logic drop;
    logic tree_miss;
    logic strip;
    logic [DW_W-1:0] flow_ptr;
    logic [PROTO_W-1:0] label_stack_upper_proto_tag;
    logic [PROTO_W-1:0] multiproto_overlay_upper_proto_tag;
  } pktl_res_t;
endpackage

// ---- src/pktl_fetch.sv ----
`timescale 1ns/100ps
module pktl_fetch
  import pktl_pkg::*;
#(
  parameter int DEPTH = FETCH_DEPTH
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // command
  input wire logic start_in,
  input wire logic [DW_W-1:0] base_in,
  input wire logic [4:0] count_in,
  output logic done_out,
  output logic [DW_W-1:0] words_out [DEPTH],
  // memory read port
  output logic mem_req_out,
  output logic [DW_W-1:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [DW_W-1:0] mem_rdata_in
);
  logic [4:0] idx; // next dword to read
  logic [4:0] cnt; // dwords wanted
  logic [DW_W-1:0] base; // structure start

  // one dword per acknowledge; request stays up until the last one
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mem_req_out <= 1'b0;
      idx <= 5'h00;
      cnt <= 5'h00;
      base <= NULL_ADDR;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        mem_req_out <= 1'b1;
        idx <= 5'h00;
        cnt <= count_in;
        base <= base_in;
      end else if (mem_req_out && mem_ack_in) begin
        idx <= idx + 5'h01;
        if (idx + 5'h01 == cnt) begin
          mem_req_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

  // captured structure words
  always_ff @(posedge clk_sys_in) begin
    if (mem_req_out && mem_ack_in) begin
      words_out[idx[3:0]] <= mem_rdata_in;
    end
  end

  assign mem_addr_out = base + DW_BYTES * {27'h000_0000, idx};
endmodule

// ---- src/pktl_hash.sv ----
`timescale 1ns/100ps
module pktl_hash
  import pktl_pkg::*;
(
  // key material
  input wire logic [HDR_W-1:0] hdr_in,
  input wire logic [HDR_W-1:0] mask_in,
  input wire logic [DW_W-1:0] flow_ptr_in,
  input wire pktl_kind_t kind_in,
  // scrambling
  input wire logic scramble_en_in,
  input wire logic [DW_W-1:0] scramble_val_in,
  // result
  output logic [HASH_W-1:0] hash_out
);
  // msb-first serial crc, state width w taken from the low bits
  function automatic logic [31:0] crc_calc(input logic [HDR_W-1:0] d, input logic [31:0] poly, input int w);
    logic [31:0] st;
    logic [31:0] msk;
    logic fb;
    msk = (w == CRC32_W) ? CRC_SEED : ((32'h0000_0001 << w) - 32'h0000_0001);
    st = CRC_SEED & msk;
    for (int i = HDR_W - 1; i >= 0; i--) begin
      fb = d[i] ^ st[w-1];
      st = (st << 1) & msk;
      if (fb) begin
        st = st ^ (poly & msk);
      end
    end
    return st;
  endfunction

  logic [HDR_W-1:0] key; // masked, optionally scrambled key

  // mask each dword, put in the flow pointer, then add the scrambling value
  always_comb begin
    key = hdr_in & mask_in;
    if (kind_in != PKTL_KIND_HDR) begin
      key[(HDR_DW-1)*DW_W +: DW_W] = flow_ptr_in; // side lookups carry the flow pointer
    end
    for (int i = 0; i < HDR_DW; i++) begin
      if (scramble_en_in) begin
        key[i*DW_W +: DW_W] = key[i*DW_W +: DW_W] + scramble_val_in;
      end
    end
  end

  // three crcs over the whole key, packed in fixed lanes
  always_comb begin
    hash_out[C8_LO +: CRC8_W] = CRC8_W'(crc_calc(key, CRC8_POLY, CRC8_W));
    hash_out[C16_LO +: CRC16_W] = CRC16_W'(crc_calc(key, CRC16_POLY, CRC16_W));
    hash_out[C32_LO +: CRC32_W] = crc_calc(key, CRC32_POLY, CRC32_W);
  end
endmodule

// ---- src/pktl_lookup.sv ----
`timescale 1ns/100ps
// Function
// - three crcs over masked 320-bit key
// - crc-8, crc-16, crc-32 in fixed lanes
// - optional 32-bit add to every dword
// - profile appended to hash: 60-bit key
// - two trees, cpu swaps active one
// - walk starts at tree root pointer
// - smaller key goes to left child
// - larger key goes to right child
// - equal key fetches first confirmation structure
// - missing node ends walk as no-match
// - trees up to 128K nodes supported
// - header copy compared to confirm hit
// - confirmed structure picks packet destination
// - relookup restarts key and walk, new profile
// - elan-id lookup rewrites flow table pointer
// - per-packet upper protocol tags are kept
// - unknown label/overlay protocol looked up, stripped
// - second matching structure sets fatal status
// - failed chain uses profile default structure
// - defaults at 1800h, 80h per profile
module pktl_lookup
  import pktl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [DW_W-1:0] reg_wdata_in,
  output logic [DW_W-1:0] reg_rdata_out,
  // tree control and status
  input wire logic tree_swap_in,
  input wire logic scramble_en_in,
  input wire logic [DW_W-1:0] scramble_val_in,
  input wire logic fatal_clr_in,
  output logic active_tree_out,
  output logic fatal_cfg_err_out,
  // parser request
  input wire logic req_valid_in,
  input wire pktl_req_t req_in,
  output logic req_ready_out,
  // lookup result
  output logic res_valid_out,
  output pktl_res_t res_out,
  // tree memory
  output logic mem_req_out,
  output logic [DW_W-1:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [DW_W-1:0] mem_rdata_in
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_HASH = 8'b0000_0010,
    ST_NODE = 8'b0000_0100,
    ST_CMP = 8'b0000_1000,
    ST_CONF = 8'b0001_0000,
    ST_CHECK = 8'b0010_0000,
    ST_DFLT = 8'b0100_0000,
    ST_ACT = 8'b1000_0000
  } pktl_state_t;

  pktl_state_t state; // walk sequencer
  pktl_req_t req_q; // packet being classified
  logic [DW_W-1:0] root [2]; // root of each tree
  logic walk_tree; // tree latched for this packet
  logic [KEY_W-1:0] key_q; // search key
  logic [HASH_W-1:0] hash; // hash of current key material
  logic [DW_W-1:0] cur_addr; // node or structure in hand
  logic matched; // a confirmation already hit
  logic [DW_W-1:0] act_q; // action of the winning structure
  logic [DW_W-1:0] act_flow_q; // flow pointer of the winning structure
  logic [2:0] relook; // relookups taken for this packet
  logic fetch_start; // kicks the dword fetcher
  logic [DW_W-1:0] fetch_base; // fetch start address
  logic [4:0] fetch_cnt; // fetch length
  logic fetch_done; // fetch finished
  logic [DW_W-1:0] words [FETCH_DEPTH]; // fetched structure
  logic [KEY_W-1:0] node_key; // key stored in the node
  logic [HDR_W-1:0] conf_hdr; // header copy in the structure
  logic hdr_hit; // header copy matches packet
  logic miss_q; // a default structure served this packet
  logic strip_q; // a side header was stripped on the way

  // default structure address of a profile
  function automatic logic [DW_W-1:0] dflt_addr(input logic [PROF_W-1:0] p);
    return DFLT_BASE + DFLT_STRIDE * {28'h000_0000, p};
  endfunction

  pktl_hash u_hash (
    .hdr_in(req_q.hdr),
    .mask_in(req_q.mask),
    .flow_ptr_in(req_q.flow_ptr),
    .kind_in(req_q.kind),
    .scramble_en_in(scramble_en_in),
    .scramble_val_in(scramble_val_in),
    .hash_out(hash)
  );

  pktl_fetch #(
    .DEPTH(FETCH_DEPTH)
  ) u_fetch (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .start_in(fetch_start),
    .base_in(fetch_base),
    .count_in(fetch_cnt),
    .done_out(fetch_done),
    .words_out(words),
    .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out),
    .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in)
  );

  // node key and confirmation copy as seen in the fetched words
  always_comb begin
    node_key = {words[NODE_KEY_HI][KEY_W-DW_W-1:0], words[NODE_KEY_LO]};
    for (int i = 0; i < HDR_DW; i++) begin
      conf_hdr[i*DW_W +: DW_W] = words[i];
    end
    hdr_hit = (conf_hdr == (req_q.hdr & req_q.mask));
  end

  assign req_ready_out = (state == ST_IDLE);

  // cpu registers: writes go to the inactive tree, which is being rebuilt
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      root[0] <= NULL_ADDR;
      root[1] <= NULL_ADDR;
      active_tree_out <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == REG_TREE_ROOT) begin
        root[~active_tree_out] <= reg_wdata_in;
      end
      if (tree_swap_in) begin
        active_tree_out <= ~active_tree_out;
      end
    end
  end

  // read data shows the active root
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= NULL_ADDR;
    end else begin
      reg_rdata_out <= (reg_addr_in == REG_TREE_ROOT) ? root[active_tree_out] : NULL_ADDR;
    end
  end

  // fatal configuration flag; a new hit beats a clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fatal_cfg_err_out <= 1'b0;
    end else if (state == ST_CHECK && fetch_done && hdr_hit && matched) begin
      fatal_cfg_err_out <= 1'b1;
    end else if (fatal_clr_in) begin
      fatal_cfg_err_out <= 1'b0;
    end
  end

  // fetcher command, issued from the sequencer's decisions
  always_comb begin
    fetch_start = 1'b0;
    fetch_base = cur_addr;
    fetch_cnt = CONF_DW;
    case (state)
      ST_HASH: begin
        fetch_start = (root[walk_tree] != NULL_ADDR);
        fetch_base = root[walk_tree];
        fetch_cnt = NODE_DW;
      end
      ST_CMP: begin
        fetch_cnt = NODE_DW;
        if (fetch_done) begin
          fetch_start = 1'b1;
          if (key_q < node_key) begin
            fetch_base = words[NODE_LEFT];
          end else if (key_q > node_key) begin
            fetch_base = words[NODE_RIGHT];
          end else begin
            fetch_base = words[NODE_CONF];
            fetch_cnt = CONF_DW;
          end
          if (fetch_base == NULL_ADDR) begin
            fetch_start = 1'b0;
          end
        end
      end
      ST_CHECK: begin
        fetch_base = words[CONF_NEXT];
        fetch_start = fetch_done && (words[CONF_NEXT] != NULL_ADDR);
      end
      ST_DFLT: begin
        fetch_start = 1'b1;
        fetch_base = dflt_addr(req_q.profile);
      end
      default: begin
        fetch_start = 1'b0;
      end
    endcase
  end

  // walk sequencer; address widths cover far more than 128K nodes
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      req_q <= '0;
      walk_tree <= 1'b0;
      key_q <= '0;
      cur_addr <= NULL_ADDR;
      matched <= 1'b0;
      act_q <= '0;
      act_flow_q <= NULL_ADDR;
      relook <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req_valid_in) begin
            req_q <= req_in; // tags arrive with the packet
            walk_tree <= active_tree_out; // tree fixed for the whole packet
            relook <= 3'h0;
            state <= ST_HASH;
          end
        end
        ST_HASH: begin
          key_q <= {req_q.profile, hash};
          matched <= 1'b0;
          state <= (root[walk_tree] != NULL_ADDR) ? ST_CMP : ST_DFLT; // empty tree misses
        end
        ST_CMP: begin
          // fetcher loads node words while waiting here
          if (fetch_done) begin
            if (fetch_start) begin
              cur_addr <= fetch_base;
              state <= (fetch_cnt == CONF_DW) ? ST_CHECK : ST_CMP;
            end else begin
              state <= ST_DFLT; // no child on that side: no-match
            end
          end
        end
        ST_CHECK: begin
          if (fetch_done) begin
            if (hdr_hit && !matched) begin
              matched <= 1'b1;
              act_q <= words[CONF_ACT];
              act_flow_q <= words[CONF_FLOW];
            end
            // the rest of the chain is still scanned to catch a double hit
            if (words[CONF_NEXT] != NULL_ADDR) begin
              cur_addr <= words[CONF_NEXT];
            end else if (hdr_hit || matched) begin
              state <= ST_ACT;
            end else begin
              state <= ST_DFLT;
            end
          end
        end
        ST_DFLT: begin
          matched <= 1'b1;
          state <= ST_NODE;
        end
        ST_NODE: begin
          // default structure arrives; only its action and flow pointer are used
          if (fetch_done) begin
            act_q <= words[CONF_ACT];
            act_flow_q <= words[CONF_FLOW];
            state <= ST_ACT;
          end
        end
        ST_ACT: begin
          if (act_q[ACT_SETFLOW]) begin
            req_q.flow_ptr <= act_flow_q;
          end
          if (req_q.kind == PKTL_KIND_LABEL && req_q.label_stack_upper_proto_tag == PROTO_UNKNOWN) begin
            req_q.label_stack_upper_proto_tag <= act_q[ACT_PROTO_LO +: PROTO_W];
          end
          if (req_q.kind == PKTL_KIND_OVERLAY && req_q.multiproto_overlay_upper_proto_tag == PROTO_UNKNOWN) begin
            req_q.multiproto_overlay_upper_proto_tag <= act_q[ACT_PROTO_LO +: PROTO_W];
          end
          if (act_q[ACT_RELOOK] && relook != MAX_RELOOK) begin
            // header stripped, search resumes as a plain header lookup
            req_q.profile <= act_q[ACT_PROF_LO +: PROF_W];
            req_q.kind <= PKTL_KIND_HDR;
            relook <= relook + 3'h1;
            state <= ST_HASH;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // result register, loaded when a packet finishes; flags gather inside so res_out never moves between pulses
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      res_valid_out <= 1'b0;
      res_out <= '0;
      miss_q <= 1'b0;
      strip_q <= 1'b0;
    end else begin
      res_valid_out <= 1'b0;
      if (state == ST_HASH && relook == 3'h0) begin
        miss_q <= 1'b0;
        strip_q <= 1'b0;
      end
      if (state == ST_DFLT) begin
        miss_q <= 1'b1;
      end
      if (state == ST_ACT && act_q[ACT_RELOOK] && req_q.kind != PKTL_KIND_HDR) begin
        strip_q <= 1'b1;
      end
      if (state == ST_ACT && !(act_q[ACT_RELOOK] && relook != MAX_RELOOK)) begin
        res_valid_out <= 1'b1;
        res_out.tree_miss <= miss_q;
        res_out.strip <= strip_q || (act_q[ACT_RELOOK] && req_q.kind != PKTL_KIND_HDR);
        res_out.dest <= pktl_dest_t'(act_q[ACT_DEST_LO +: 2]);
        res_out.drop <= act_q[ACT_DROP];
        res_out.flow_ptr <= act_q[ACT_SETFLOW] ? act_flow_q : req_q.flow_ptr;
        res_out.label_stack_upper_proto_tag <= req_q.label_stack_upper_proto_tag;
        res_out.multiproto_overlay_upper_proto_tag <= req_q.multiproto_overlay_upper_proto_tag;
      end
    end
  end
endmodule

// ---- verif/pktl_lookup_props.sv ----
`timescale 1ns/100ps
// timing relations watched at the lookup engine's own pins
module pktl_lookup_props
  import pktl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // register and control
  input wire logic [11:0] reg_addr_in,
  input wire logic [DW_W-1:0] reg_rdata_out,
  input wire logic tree_swap_in,
  input wire logic fatal_clr_in,
  input wire logic active_tree_out,
  input wire logic fatal_cfg_err_out,
  // request and result
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic res_valid_out,
  input wire pktl_res_t res_out,
  // tree memory
  input wire logic mem_req_out,
  input wire logic [DW_W-1:0] mem_addr_out,
  input wire logic mem_ack_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_unmapped_reads_zero: assert property (reg_addr_in != 12'hF18 |=> reg_rdata_out == 32'h0000_0000)
    else $error("unmapped register read is not zero");
  a_swap_flips_tree: assert property (tree_swap_in |=> active_tree_out != $past(active_tree_out))
    else $error("swap pulse did not flip the active tree");
  a_tree_held_still: assert property (!tree_swap_in |=> $stable(active_tree_out))
    else $error("active tree changed without a swap");
  a_fatal_sticky: assert property (fatal_cfg_err_out && !fatal_clr_in |=> fatal_cfg_err_out)
    else $error("fatal status dropped without a clear");
  a_result_pulse: assert property (res_valid_out |=> !res_valid_out)
    else $error("result valid longer than one cycle");
  a_result_held: assert property (!res_valid_out |-> $stable(res_out))
    else $error("result changed without a result pulse");
  a_busy_after_take: assert property (req_valid_in && req_ready_out |=> !req_ready_out)
    else $error("engine still ready after taking a request");
  a_ready_after_res: assert property (res_valid_out |=> req_ready_out)
    else $error("engine not ready after a result");
  a_fetch_held: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("memory request dropped or moved before acknowledge");
  a_idle_no_fetch: assert property (req_ready_out |-> !mem_req_out)
    else $error("memory read while idle");
endmodule

bind pktl_lookup pktl_lookup_props i_pktl_lookup_props (.clk_sys_in, .rst_in, .reg_addr_in, .reg_rdata_out,
  .tree_swap_in, .fatal_clr_in, .active_tree_out, .fatal_cfg_err_out, .req_valid_in, .req_ready_out,
  .res_valid_out, .res_out, .mem_req_out, .mem_addr_out, .mem_ack_in);

// ---- verif/pktl_lookup_test.sv ----
`timescale 1ns/100ps
module pktl_lookup_test;
  import pktl_pkg::*;
  // design inputs
  logic clk_sys_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, tree_swap_in = 1'b0, fatal_clr_in = 1'b0;
  logic scramble_en_in = 1'b1, req_valid_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0000_0000, scramble_val_in = 32'h1234_5678, mem_rdata_in;
  pktl_req_t req_in = '0;
  // design outputs
  logic [31:0] reg_rdata_out, mem_addr_out;
  logic active_tree_out, fatal_cfg_err_out, req_ready_out, res_valid_out, mem_req_out, mem_ack_in;
  pktl_res_t res_out;
  logic [1:0] mem_wait = 2'h0; // memory wait states
  logic [31:0] rd; // register read result
  int n_mismatch = 0, check_count = 0, cycles = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  pktl_lookup i_pktl_lookup (.clk_sys_in, .rst_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
    .tree_swap_in, .scramble_en_in, .scramble_val_in, .fatal_clr_in, .active_tree_out, .fatal_cfg_err_out,
    .req_valid_in, .req_in, .req_ready_out, .res_valid_out, .res_out, .mem_req_out, .mem_addr_out,
    .mem_ack_in, .mem_rdata_in);
  pktl_mem_model i_pktl_mem_model (.clk_sys_in, .rst_in, .mem_req_in(mem_req_out), .mem_addr_in(mem_addr_out),
    .wait_in(mem_wait), .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang must still end in the verdict
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_sys_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_sys_in);
    reg_wr_in = 1'b0;
  endtask

  // read data is registered: sample one cycle after the address
  task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    @(negedge clk_sys_in);
    d = reg_rdata_out;
  endtask

  // node dwords: key lo, key hi, left, right, confirmation
  task automatic node(input logic [31:0] a, input logic [31:0] hi, input logic [31:0] l, input logic [31:0] r);
    i_pktl_mem_model.put(a, hi[31] ? 32'hFFFF_FFFF : 32'h0000_0000);
    i_pktl_mem_model.put(a + 32'h0000_0004, {4'h0, hi[27:0]});
    i_pktl_mem_model.put(a + 32'h0000_0008, l);
    i_pktl_mem_model.put(a + 32'h0000_000C, r);
    i_pktl_mem_model.put(a + 32'h0000_0010, 32'h0000_0000);
  endtask

  task automatic test_reset();
    check("ready", req_ready_out, 1);
    check("tree", active_tree_out, 0);
    check("fatal", fatal_cfg_err_out, 0);
    check("result", res_valid_out, 0);
  endtask

  // root goes to the inactive tree and shows only after a swap; other offsets ignored
  task automatic test_regs();
    reg_write(12'hF18, 32'h0000_0100);
    reg_write(12'hF1C, 32'h0000_0BAD);
    reg_read(12'hF1C, rd);
    check("unmapped read", rd, 0);
    @(negedge clk_sys_in);
    tree_swap_in = 1'b1;
    @(negedge clk_sys_in);
    tree_swap_in = 1'b0;
    check("tree after swap", active_tree_out, 1);
    reg_write(12'hF18, 32'h0000_0200);
    reg_read(12'hF18, rd);
    check("active root", rd, 32'h0000_0100);
  endtask

  // node keys are picked from the profile nibble so the branch never depends on the hash
  task automatic lookup_chk(input logic [3:0] p, input logic [31:0] child, input bit swap_mid, input logic [1:0] w);
    logic [31:0] dflt;
    int n;
    dflt = 32'h0000_1800 + 32'h0000_0080 * p;
    mem_wait = w;
    i_pktl_mem_model.seen.delete();
    @(negedge clk_sys_in);
    req_in.profile = p;
    req_in.hdr = {10{32'hA5A5_0000 | p}};
    req_in.mask = {HDR_W{1'b1}};
    req_valid_in = 1'b1;
    @(negedge clk_sys_in);
    req_valid_in = 1'b0;
    if (swap_mid) begin
      tree_swap_in = 1'b1;
      @(negedge clk_sys_in);
      tree_swap_in = 1'b0;
    end
    for (n = 0; n < 600 && res_valid_out !== 1'b1; n++) begin
      @(negedge clk_sys_in);
    end
    check("result seen", res_valid_out, 1);
    check("child visited", i_pktl_mem_model.seen.exists(child), 1);
    check("default read", i_pktl_mem_model.seen.exists(dflt + 32'h0000_002C), 1);
    check("dest", res_out.dest, p[1:0]);
    check("miss", res_out.tree_miss, 1);
    check("flow", res_out.flow_ptr, 32'h0000_1000 | p);
  endtask

  initial begin
    logic [3:0] profs [4];
    profs = '{4'h4, 4'h9, 4'hE, 4'h7};
    // tree 1 root splits on profile 8; leaves have null children
    node(32'h0000_0100, 32'h0800_0000, 32'h0000_0300, 32'h0000_0400);
    node(32'h0000_0300, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    node(32'h0000_0400, 32'h8FFF_FFFF, 32'h0000_0000, 32'h0000_0000);
    // tree 0 sends every profile to the same leaf
    node(32'h0000_0200, 32'h0800_0000, 32'h0000_0500, 32'h0000_0500);
    node(32'h0000_0500, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    // per-profile defaults: dest from profile, replace flow pointer
    for (int p = 0; p < 16; p++) begin
      i_pktl_mem_model.put(32'h0000_182C + 32'h80 * p, {24'h0, 6'h20, p[1:0]});
      i_pktl_mem_model.put(32'h0000_1830 + 32'h80 * p, 32'h0000_1000 | p);
    end
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
    test_reset();
    test_regs();
    for (int i = 0; i < 4; i++) begin
      lookup_chk(profs[i], profs[i] < 8 ? 32'h0000_0300 : 32'h0000_0400, 1'b0, i[1:0]);
    end
    lookup_chk(4'h4, 32'h0000_0300, 1'b1, 2'h3);
    check("tree swapped", active_tree_out, 0);
    lookup_chk(4'h4, 32'h0000_0500, 1'b0, 2'h0);
    @(negedge clk_sys_in);
    fatal_clr_in = 1'b1;
    @(negedge clk_sys_in);
    fatal_clr_in = 1'b0;
    check("fatal clear", fatal_cfg_err_out, 0);
    give_verdict();
  end
endmodule

// ---- verif/pktl_mem_model.sv ----
`timescale 1ns/100ps
// behavioural tree memory: one dword per acknowledge, optional wait states
module pktl_mem_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // read port
  input wire logic mem_req_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic [1:0] wait_in,
  output logic mem_ack_out,
  output logic [31:0] mem_rdata_out
);
  logic [31:0] mem [logic [31:0]]; // sparse contents
  bit seen [logic [31:0]]; // addresses read since last clear
  logic [1:0] wait_cnt; // wait states spent on this dword

  // answer after wait_in idle cycles; data outside the ack cycle is inverted so stale data never looks valid
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= 32'h0000_0000;
      wait_cnt <= 2'h0;
    end else if (mem_req_in && !mem_ack_out && wait_cnt >= wait_in) begin
      mem_ack_out <= 1'b1;
      mem_rdata_out <= mem.exists(mem_addr_in) ? mem[mem_addr_in] : 32'h0000_0000;
      seen[mem_addr_in] = 1'b1;
      wait_cnt <= 2'h0;
    end else begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in && !mem_ack_out) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end

  // preload one dword
  task automatic put(input logic [31:0] a, input logic [31:0] d);
    mem[a] = d;
  endtask
endmodule
